/* File: core/tsdc_pkg.sv */
// package for the timer sync / dma / control block: map, fields, codes, state
// assumes a 32-bit register port with byte addresses, one word per register
`default_nettype none
package tsdc_pkg;

    localparam int CNT_W = 16;
    localparam int MSM_DELAY = 4; // own trigger delay matching a slave's sync path

    // register byte offsets
    localparam logic [7:0] OFS_CTL0 = 8'h00;
    localparam logic [7:0] OFS_MASTER = 8'h04;
    localparam logic [7:0] OFS_SLAVE = 8'h08;
    localparam logic [7:0] OFS_DMA_EN = 8'h0c;
    localparam logic [7:0] OFS_FLAGS = 8'h10;
    localparam logic [7:0] OFS_SW_EVENT = 8'h14;
    localparam logic [7:0] OFS_CH_CTL = 8'h18;
    localparam logic [7:0] OFS_COUNTER = 8'h24;
    localparam logic [7:0] OFS_PRESCALE = 8'h28;
    localparam logic [7:0] OFS_RELOAD = 8'h2c;
    localparam logic [7:0] OFS_CH0_CMP = 8'h34;
    localparam logic [7:0] OFS_DMA_CFG = 8'h48;
    localparam logic [7:0] OFS_DMA_BUF = 8'h4c;
    localparam logic [7:0] OFS_DEBUG = 8'h50;

    // counter_control fields
    localparam int CTL0_CEN = 0;
    localparam int CTL0_UPD_INH = 1;
    localparam int CTL0_UPD_SRC = 2;
    localparam int CTL0_ONE_SHOT = 3;
    localparam int CTL0_DIR = 4;
    localparam int CTL0_CAM = 5;
    localparam int CTL0_RELOAD_SHADOW_ENABLE = 7;
    localparam int CTL0_SAMPLE_CLOCK_DIVIDE = 8;
    // fields of the other registers
    localparam int MASTER_SEL = 0;
    localparam int SLAVE_MODE = 0;
    localparam int SLAVE_TSS = 4;
    localparam int SLAVE_MSM = 7;
    localparam int DMA_EN_UPD = 0;
    localparam int FLAG_UPD = 0;
    localparam int FLAG_CMP = 1;
    localparam int FLAG_TRG = 2;
    localparam int SW_UPDATE = 0;
    localparam int CH_MODE = 0;
    localparam int DMA_START = 0;
    localparam int DMA_BURST = 8;
    localparam int DEBUG_HOLD = 0;

    // reset values
    localparam logic [31:0] CTL0_RST = 32'h0000_0000;
    localparam logic [15:0] RELOAD_RST = 16'hffff;
    localparam logic [15:0] DATA16_RST = 16'h0000;

    // slave modes
    localparam logic [2:0] SMS_OFF = 3'h0;
    localparam logic [2:0] SMS_RESTART = 3'h4;
    localparam logic [2:0] SMS_PAUSE = 3'h5;
    localparam logic [2:0] SMS_EVENT = 3'h6;
    localparam logic [2:0] SMS_EXTCLK = 3'h7;
    // trigger sources 0..3 are internal_trigger_in[n]
    localparam logic [2:0] TSS_ITI2 = 3'h2;
    localparam logic [2:0] TSS_CH0_EDGE = 3'h4;
    localparam logic [2:0] TSS_CH0_LEVEL = 3'h5;
    // master output select
    localparam logic [2:0] MMS_RESET = 3'h0;
    localparam logic [2:0] MMS_ENABLE = 3'h1;
    localparam logic [2:0] MMS_UPDATE = 3'h2;
    localparam logic [2:0] MMS_CMP_PULSE = 3'h3;
    localparam logic [2:0] MMS_CMP_OUT = 3'h4;
    // sample clock divide and alignment
    localparam logic [1:0] SAMPLE_CLOCK_DIVIDE_1 = 2'h0;
    localparam logic [1:0] SAMPLE_CLOCK_DIVIDE_2 = 2'h1;
    localparam logic [1:0] SAMPLE_CLOCK_DIVIDE_4 = 2'h2;
    localparam logic [1:0] CAM_EDGE = 2'h0;
    localparam logic [1:0] CAM_DOWN = 2'h1;
    localparam logic [1:0] CAM_UP = 2'h2;
    localparam logic [1:0] CH_OUTPUT = 2'h0;

    typedef struct packed {
        logic counter_enable_bit;
        logic upd_inhibit;
        logic upd_src;
        logic one_shot;
        logic dir;
        logic reload_shadow_enable;
        logic [1:0] alignment_mode;
        logic [1:0] sample_clock_divide;
        logic [1:0] ch_mode;
        logic [2:0] mmc;
        logic [2:0] sms;
        logic [2:0] tss;
        logic master_slave_sync;
        logic dma_upd_en;
        logic hold;
        logic [4:0] dma_start;
        logic [4:0] dma_burst;
        logic [4:0] dma_idx;
        logic dma_act;
        logic dma_req;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] psc;
        logic [CNT_W-1:0] psc_cnt;
        logic [CNT_W-1:0] car;
        logic [CNT_W-1:0] car_sh;
        logic [CNT_W-1:0] cmp;
        logic flag_upd;
        logic flag_cmp;
        logic flag_trg;
        logic trigger_out;
        logic [31:0] rdata;
        logic [3:0] iti_s1;
        logic [3:0] iti_s2;
        logic [3:0] iti_s3;
        logic [3:0] iti_st;
        logic ci_s1;
        logic ci_s2;
        logic ci_s3;
        logic ci_st;
        logic ci_smp;
        logic [1:0] dts_cnt;
        logic [MSM_DELAY-1:0] msm_dly;
    } tsdc_state_t;

endpackage

`default_nettype wire

/* File: core/tsdc_timer.sv */
// timer core: master/slave triggering, dma burst through a buffer register,
// counter control register, debug hold, sample clock divider
// assumes one 100 MHz clock, async active-low reset, single-cycle register port
//
// Summary of operation
// [RULE1] master drives trigger_out from selected event
// [RULE2] slave acts on trigger per slave mode
// [RULE3] select 010 outputs update event pulse
// [RULE4] select 001 outputs counter enable level
// [RULE5] source 010 takes internal trigger input 2
// [RULE6] mode 111 counts on each trigger edge
// [RULE7] mode 110 trigger sets counter enable
// [RULE8] source 100 takes channel0 input edge
// [RULE9] sync bit delays own trigger response
// [RULE10] dma buffer access routed to start register
// [RULE11] burst length plus one requests, word steps
// [RULE12] new dma event restarts the burst
// [RULE13] debug halt with hold bit freezes counter
// [RULE14] bits 9:8 divide sample clock 1/2/4
// [RULE15] bit 7 shadows reload until update event
// [RULE16] alignment 00 edge, else center counting
// [RULE17] alignment 01 compare flag only counting down
// [RULE18] alignment 10 compare flag only counting up
// [RULE19] alignment 11 compare flag both directions
// [RULE20] control register accessed by full words
// [RULE21] bit 4 direction, read-only when centered
// [RULE22] bit 3 stops counter at update event
// [RULE23] bit 1 blocks update, still reinitialises
// [RULE24] software sets enable for extclk/pause
// [RULE25] internal triggers synchronised before use
`timescale 1ns/1ps
`default_nettype none

module tsdc_timer (
    input wire logic i_clk, // timer clock
    input wire logic i_rst_n, // async reset, active low
    input wire logic [7:0] i_addr, // register byte address
    input wire logic [31:0] i_wr_data, // write data
    input wire logic i_wr_en, // write strobe
    input wire logic i_rd_en, // read strobe
    output logic [31:0] o_rd_data, // read data, cycle after strobe
    input wire logic [3:0] i_internal_trigger_in, // triggers from other timers
    input wire logic i_channel0_input, // channel 0 pin
    input wire logic i_debug_halted, // processor halted in debug
    output logic o_trigger_out, // trigger to other timers
    output logic o_dma_req // dma request level
);

    tsdc_pkg::tsdc_state_t q;
    tsdc_pkg::tsdc_state_t d;

    logic buf_hit;
    logic [5:0] dma_word;
    logic [7:0] eff_addr;
    logic dts_tick;
    logic ci_edge;
    logic [3:0] iti_edge;
    logic trig_edge;
    logic trig_lvl;
    logic trig_act;
    logic encoder;
    logic halted;
    logic sw_req;
    logic reinit;
    logic tick;
    logic step;
    logic ovf;
    logic uev;
    logic uev_flag;
    logic cmp_hit;
    logic dir_ok;
    logic dma_evt;
    logic [15:0] car_a;
    logic [15:0] cnt_n;
    logic dir_n;
    logic [31:0] rv;

    always_comb begin
        d = q;
        // buffer accesses are redirected to the burst window
        buf_hit = (i_wr_en || i_rd_en) && (i_addr == tsdc_pkg::OFS_DMA_BUF);
        dma_word = {1'b0, q.dma_start} + {1'b0, q.dma_idx};
        eff_addr = buf_hit ? {dma_word, 2'b00} : i_addr; // RULE10

        // three-stage synchronisers, level accepted when stages 2 and 3 agree
        d.iti_s1 = i_internal_trigger_in;
        d.iti_s2 = q.iti_s1;
        d.iti_s3 = q.iti_s2;
        for (int i = 0; i < 4; i++) begin
            if (q.iti_s2[i] == q.iti_s3[i]) begin
                d.iti_st[i] = q.iti_s3[i]; // RULE25
            end
        end
        d.ci_s1 = i_channel0_input;
        d.ci_s2 = q.ci_s1;
        d.ci_s3 = q.ci_s2;
        if (q.ci_s2 == q.ci_s3) begin
            d.ci_st = q.ci_s3;
        end
        iti_edge = d.iti_st & ~q.iti_st;

        // sample clock enable; reserved code behaves as divide by one
        d.dts_cnt = q.dts_cnt + 2'h1;
        unique case (q.sample_clock_divide)
            tsdc_pkg::SAMPLE_CLOCK_DIVIDE_2: dts_tick = q.dts_cnt[0]; // RULE14
            tsdc_pkg::SAMPLE_CLOCK_DIVIDE_4: dts_tick = (q.dts_cnt == 2'h3); // RULE14
            default: dts_tick = 1'b1;
        endcase
        if (dts_tick) begin
            d.ci_smp = q.ci_st;
        end
        ci_edge = dts_tick && q.ci_st && !q.ci_smp;

        // trigger source select
        trig_edge = 1'b0;
        trig_lvl = 1'b0;
        if (q.tss < tsdc_pkg::TSS_CH0_EDGE) begin
            trig_edge = iti_edge[q.tss[1:0]]; // RULE5
            trig_lvl = q.iti_st[q.tss[1:0]];
        end else if (q.tss == tsdc_pkg::TSS_CH0_EDGE) begin
            trig_edge = ci_edge; // RULE8
            trig_lvl = q.ci_smp;
        end else if (q.tss == tsdc_pkg::TSS_CH0_LEVEL) begin
            trig_edge = ci_edge;
            trig_lvl = q.ci_smp;
        end

        // sync mode holds back the own response to line up with the slave
        d.msm_dly = {q.msm_dly[tsdc_pkg::MSM_DELAY-2:0], trig_edge};
        trig_act = q.master_slave_sync ? q.msm_dly[tsdc_pkg::MSM_DELAY-1] : trig_edge; // RULE9

        // counter clocking
        encoder = (q.sms != tsdc_pkg::SMS_OFF) && (q.sms < tsdc_pkg::SMS_RESTART);
        halted = q.hold && i_debug_halted; // RULE13
        sw_req = i_wr_en && (eff_addr == tsdc_pkg::OFS_SW_EVENT) &&
            i_wr_data[tsdc_pkg::SW_UPDATE];
        reinit = sw_req || ((q.sms == tsdc_pkg::SMS_RESTART) && trig_act); // RULE2
        // enable must come from software in external clock and pause modes
        tick = q.counter_enable_bit && !halted && !encoder && // RULE24
            ((q.sms != tsdc_pkg::SMS_EXTCLK) || trig_act) && // RULE6
            ((q.sms != tsdc_pkg::SMS_PAUSE) || trig_lvl); // RULE2
        step = 1'b0;
        if (tick) begin
            if (q.psc_cnt >= q.psc) begin
                d.psc_cnt = tsdc_pkg::DATA16_RST;
                step = 1'b1;
            end else begin
                d.psc_cnt = q.psc_cnt + 16'h0001;
            end
        end

        car_a = q.reload_shadow_enable ? q.car_sh : q.car; // RULE15
        cnt_n = q.cnt;
        dir_n = q.dir;
        ovf = 1'b0;
        if (step) begin
            if (q.alignment_mode == tsdc_pkg::CAM_EDGE) begin // RULE16
                if (!q.dir) begin
                    if (q.cnt >= car_a) begin
                        cnt_n = 16'h0000;
                        ovf = 1'b1;
                    end else begin
                        cnt_n = q.cnt + 16'h0001;
                    end
                end else if (q.cnt == 16'h0000) begin
                    cnt_n = car_a;
                    ovf = 1'b1;
                end else begin
                    cnt_n = q.cnt - 16'h0001;
                end
            end else if (!q.dir) begin // RULE16
                if (({1'b0, q.cnt} + 17'h0_0001) >= {1'b0, car_a}) begin
                    cnt_n = car_a;
                    dir_n = 1'b1;
                    ovf = 1'b1;
                end else begin
                    cnt_n = q.cnt + 16'h0001;
                end
            end else if (q.cnt <= 16'h0001) begin
                cnt_n = 16'h0000;
                dir_n = 1'b0;
                ovf = 1'b1;
            end else begin
                cnt_n = q.cnt - 16'h0001;
            end
        end
        unique case (q.alignment_mode)
            tsdc_pkg::CAM_EDGE: dir_ok = 1'b1;
            tsdc_pkg::CAM_DOWN: dir_ok = q.dir; // RULE17
            tsdc_pkg::CAM_UP: dir_ok = !q.dir; // RULE18
            default: dir_ok = 1'b1; // RULE19
        endcase
        cmp_hit = step && (cnt_n == q.cmp) && (q.ch_mode == tsdc_pkg::CH_OUTPUT) && dir_ok;
        d.cnt = cnt_n;
        d.dir = dir_n;
        if (reinit) begin
            // counter and prescaler restart even when updates are blocked
            d.psc_cnt = tsdc_pkg::DATA16_RST; // RULE23
            d.cnt = (q.dir && q.alignment_mode == tsdc_pkg::CAM_EDGE) ? car_a : 16'h0000;
            if (q.alignment_mode != tsdc_pkg::CAM_EDGE) begin
                d.dir = 1'b0;
            end
        end
        uev = !q.upd_inhibit && (ovf || reinit); // RULE23
        uev_flag = uev && (!q.upd_src || ovf);
        if (uev) begin
            d.car_sh = q.car; // RULE15
        end
        dma_evt = uev_flag && q.dma_upd_en;

        // register writes; control register is word-wide only
        if (i_wr_en) begin
            unique case (eff_addr)
                tsdc_pkg::OFS_CTL0: begin // RULE20
                    d.counter_enable_bit = i_wr_data[tsdc_pkg::CTL0_CEN];
                    d.upd_inhibit = i_wr_data[tsdc_pkg::CTL0_UPD_INH];
                    d.upd_src = i_wr_data[tsdc_pkg::CTL0_UPD_SRC];
                    d.one_shot = i_wr_data[tsdc_pkg::CTL0_ONE_SHOT];
                    d.alignment_mode = i_wr_data[tsdc_pkg::CTL0_CAM +: 2];
                    d.reload_shadow_enable = i_wr_data[tsdc_pkg::CTL0_RELOAD_SHADOW_ENABLE];
                    d.sample_clock_divide = i_wr_data[tsdc_pkg::CTL0_SAMPLE_CLOCK_DIVIDE +: 2];
                    if (q.alignment_mode == tsdc_pkg::CAM_EDGE && !encoder) begin
                        d.dir = i_wr_data[tsdc_pkg::CTL0_DIR]; // RULE21
                    end
                end
                tsdc_pkg::OFS_MASTER: d.mmc = i_wr_data[tsdc_pkg::MASTER_SEL +: 3];
                tsdc_pkg::OFS_SLAVE: begin
                    d.sms = i_wr_data[tsdc_pkg::SLAVE_MODE +: 3];
                    d.tss = i_wr_data[tsdc_pkg::SLAVE_TSS +: 3];
                    d.master_slave_sync = i_wr_data[tsdc_pkg::SLAVE_MSM];
                end
                tsdc_pkg::OFS_DMA_EN: d.dma_upd_en = i_wr_data[tsdc_pkg::DMA_EN_UPD];
                tsdc_pkg::OFS_FLAGS: begin
                    d.flag_upd = q.flag_upd && !i_wr_data[tsdc_pkg::FLAG_UPD];
                    d.flag_cmp = q.flag_cmp && !i_wr_data[tsdc_pkg::FLAG_CMP];
                    d.flag_trg = q.flag_trg && !i_wr_data[tsdc_pkg::FLAG_TRG];
                end
                tsdc_pkg::OFS_CH_CTL: d.ch_mode = i_wr_data[tsdc_pkg::CH_MODE +: 2];
                tsdc_pkg::OFS_COUNTER: d.cnt = i_wr_data[15:0];
                tsdc_pkg::OFS_PRESCALE: d.psc = i_wr_data[15:0];
                tsdc_pkg::OFS_RELOAD: d.car = i_wr_data[15:0];
                tsdc_pkg::OFS_CH0_CMP: d.cmp = i_wr_data[15:0];
                tsdc_pkg::OFS_DMA_CFG: begin
                    d.dma_start = i_wr_data[tsdc_pkg::DMA_START +: 5];
                    d.dma_burst = i_wr_data[tsdc_pkg::DMA_BURST +: 5];
                end
                tsdc_pkg::OFS_DEBUG: d.hold = i_wr_data[tsdc_pkg::DEBUG_HOLD];
                default: ;
            endcase
        end
        if (!q.reload_shadow_enable && !uev) begin
            d.car_sh = d.car;
        end

        // hardware events win over software in the same cycle
        if (q.one_shot && (ovf || uev)) begin
            d.counter_enable_bit = 1'b0; // RULE22
        end
        if (q.sms == tsdc_pkg::SMS_EVENT && trig_act) begin
            d.counter_enable_bit = 1'b1; // RULE7
        end
        if (uev_flag) begin
            d.flag_upd = 1'b1;
        end
        if (cmp_hit) begin
            d.flag_cmp = 1'b1;
        end
        if (trig_edge && q.sms != tsdc_pkg::SMS_OFF) begin
            d.flag_trg = 1'b1; // RULE9
        end

        // dma burst sequencing; request drops for a cycle after each access but the last, which ends the burst
        if (dma_evt) begin
            d.dma_act = 1'b1; // RULE12
            d.dma_idx = 5'h00;
            d.dma_req = 1'b1;
        end else if (buf_hit && q.dma_act) begin
            d.dma_req = 1'b0;
            if (q.dma_idx == q.dma_burst) begin
                d.dma_act = 1'b0; // RULE11
                d.dma_idx = 5'h00;
            end else begin
                d.dma_idx = q.dma_idx + 5'h01; // RULE11
            end
        end else if (q.dma_act && !q.dma_req) begin
            d.dma_req = 1'b1; // RULE10
        end

        // trigger output, built from next-state so it leaves a flop
        unique case (q.mmc)
            tsdc_pkg::MMS_RESET: d.trigger_out = reinit; // RULE1
            tsdc_pkg::MMS_ENABLE: d.trigger_out = d.counter_enable_bit || (d.master_slave_sync && (|d.msm_dly)); // RULE4
            tsdc_pkg::MMS_UPDATE: d.trigger_out = uev; // RULE3
            tsdc_pkg::MMS_CMP_PULSE: d.trigger_out = cmp_hit; // RULE1
            tsdc_pkg::MMS_CMP_OUT: d.trigger_out = (d.cnt < d.cmp); // RULE1
            default: d.trigger_out = 1'b0;
        endcase

        // read path, data valid only in the cycle after the strobe
        rv = 32'h0000_0000;
        unique case (eff_addr)
            tsdc_pkg::OFS_CTL0: begin
                rv[tsdc_pkg::CTL0_CEN] = q.counter_enable_bit;
                rv[tsdc_pkg::CTL0_UPD_INH] = q.upd_inhibit;
                rv[tsdc_pkg::CTL0_UPD_SRC] = q.upd_src;
                rv[tsdc_pkg::CTL0_ONE_SHOT] = q.one_shot;
                rv[tsdc_pkg::CTL0_DIR] = q.dir;
                rv[tsdc_pkg::CTL0_CAM +: 2] = q.alignment_mode;
                rv[tsdc_pkg::CTL0_RELOAD_SHADOW_ENABLE] = q.reload_shadow_enable;
                rv[tsdc_pkg::CTL0_SAMPLE_CLOCK_DIVIDE +: 2] = q.sample_clock_divide;
            end
            tsdc_pkg::OFS_MASTER: rv[tsdc_pkg::MASTER_SEL +: 3] = q.mmc;
            tsdc_pkg::OFS_SLAVE: begin
                rv[tsdc_pkg::SLAVE_MODE +: 3] = q.sms;
                rv[tsdc_pkg::SLAVE_TSS +: 3] = q.tss;
                rv[tsdc_pkg::SLAVE_MSM] = q.master_slave_sync;
            end
            tsdc_pkg::OFS_DMA_EN: rv[tsdc_pkg::DMA_EN_UPD] = q.dma_upd_en;
            tsdc_pkg::OFS_FLAGS: begin
                rv[tsdc_pkg::FLAG_UPD] = q.flag_upd;
                rv[tsdc_pkg::FLAG_CMP] = q.flag_cmp;
                rv[tsdc_pkg::FLAG_TRG] = q.flag_trg;
            end
            tsdc_pkg::OFS_CH_CTL: rv[tsdc_pkg::CH_MODE +: 2] = q.ch_mode;
            tsdc_pkg::OFS_COUNTER: rv[15:0] = q.cnt;
            tsdc_pkg::OFS_PRESCALE: rv[15:0] = q.psc;
            tsdc_pkg::OFS_RELOAD: rv[15:0] = q.car;
            tsdc_pkg::OFS_CH0_CMP: rv[15:0] = q.cmp;
            tsdc_pkg::OFS_DMA_CFG: begin
                rv[tsdc_pkg::DMA_START +: 5] = q.dma_start;
                rv[tsdc_pkg::DMA_BURST +: 5] = q.dma_burst;
            end
            tsdc_pkg::OFS_DEBUG: rv[tsdc_pkg::DEBUG_HOLD] = q.hold;
            default: ;
        endcase
        d.rdata = i_rd_en ? rv : 32'h0000_0000;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '0;
            q.car <= tsdc_pkg::RELOAD_RST;
            q.car_sh <= tsdc_pkg::RELOAD_RST;
        end else begin
            q <= d;
        end
    end

    assign o_rd_data = q.rdata;
    assign o_trigger_out = q.trigger_out;
    assign o_dma_req = q.dma_req;

    AST_UPDATE_TRIGGER_OUT: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE3
        (q.mmc == tsdc_pkg::MMS_UPDATE && uev) |=> o_trigger_out)
        else $error("update event not sent on trigger output");

    AST_ENABLE_TRIGGER_OUT: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE4
        (q.mmc == tsdc_pkg::MMS_ENABLE && $stable(q.mmc) && !q.master_slave_sync) |-> (o_trigger_out == q.counter_enable_bit))
        else $error("trigger output does not follow counter enable");

    AST_EXTCLK_STEP: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE6
        (q.sms == tsdc_pkg::SMS_EXTCLK && trig_act && q.counter_enable_bit && !halted && !reinit
            && q.psc_cnt >= q.psc && q.alignment_mode == tsdc_pkg::CAM_EDGE && car_a != 16'h0000
            && !(i_wr_en && eff_addr == tsdc_pkg::OFS_COUNTER)) |=> $changed(q.cnt))
        else $error("external clock edge did not advance counter");

    AST_EVENT_CEN: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE7
        (q.sms == tsdc_pkg::SMS_EVENT && trig_act) |=> q.counter_enable_bit)
        else $error("event mode trigger did not set enable");

    AST_MSM_DELAY: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE9
        (q.master_slave_sync && $stable(q.master_slave_sync) && trig_edge && q.sms == tsdc_pkg::SMS_EVENT
            && $stable(q.sms)) ##4 (q.master_slave_sync && q.sms == tsdc_pkg::SMS_EVENT) |=> q.counter_enable_bit)
        else $error("synchronised trigger response not after fixed delay");

    AST_DMA_LAST: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE11
        (buf_hit && q.dma_act && q.dma_idx == q.dma_burst && !dma_evt) |=> !q.dma_act)
        else $error("dma burst ran past its length");

    AST_DMA_NEXT: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE11
        (buf_hit && q.dma_act && q.dma_idx != q.dma_burst && !dma_evt)
            |=> !o_dma_req ##1 o_dma_req)
        else $error("next dma request not raised");

    AST_DMA_RESTART: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE12
        dma_evt |=> (q.dma_act && q.dma_req && q.dma_idx == 5'h00))
        else $error("dma event did not restart the burst");

    AST_DEBUG_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE13
        (halted && !reinit && !(i_wr_en && eff_addr == tsdc_pkg::OFS_COUNTER))
            |=> $stable(q.cnt))
        else $error("counter moved during debug hold");

    AST_SHADOW_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE15
        (q.reload_shadow_enable && !uev) |=> $stable(q.car_sh))
        else $error("reload shadow changed without update");

    AST_CMP_DOWN_ONLY: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE17
        ($rose(q.flag_cmp) && $past(q.alignment_mode) == tsdc_pkg::CAM_DOWN) |-> $past(q.dir))
        else $error("compare flag set while counting up");

    AST_ONE_SHOT: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE22
        (q.one_shot && ovf && !(q.sms == tsdc_pkg::SMS_EVENT && trig_act)) |=> !q.counter_enable_bit)
        else $error("one-shot counter kept running");

    AST_INHIBIT: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE23
        (q.upd_inhibit && sw_req) |=> (!$rose(q.flag_upd) && q.psc_cnt == 16'h0000))
        else $error("blocked update still signalled");

    AST_SYNC_AGREE: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE25
        $rose(q.iti_st[2]) |-> ($past(q.iti_s2[2]) && $past(q.iti_s3[2])))
        else $error("trigger accepted before synchroniser agreed");

endmodule

`default_nettype wire

/* File: verification/tsdc_peer.sv */
// peer timer model: raises trigger line 2 towards the block on request
// assumes the bench's clock and reset; request held for several cycles
`timescale 1ns/1ps
`default_nettype none
module tsdc_peer (
    input wire logic i_clk, // timer clock
    input wire logic i_rst_n, // async reset, active low
    input wire logic i_fire, // hold high to emit trigger
    output logic [3:0] o_iti // trigger lines
);
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n)
            o_iti <= 4'h0;
        else
            o_iti <= {1'b0, i_fire, 2'b00};
    end
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// self-checking bench for the timer block: registers, triggers, dma, hold
// assumes the peer model drives trigger input 2
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, halt = 0, fire = 0, ch0 = 0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic [3:0] iti;
    logic trg, dreq;
    int err_total = 0, compares = 0, cycles = 0;
    typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] e;} tsdc_row_t;
    tsdc_row_t rows [7] = '{
        '{8'h00, 32'h0000_0380, 32'h0000_0380},
        '{8'h00, 32'h0000_0020, 32'h0000_0020},
        '{8'h00, 32'h0000_0030, 32'h0000_0020},
        '{8'h00, 32'hffff_fc00, 32'h0000_0000},
        '{8'h3c, 32'h0000_1234, 32'h0000_0000},
        '{8'h2c, 32'h0000_0007, 32'h0000_0007},
        '{8'h48, 32'h0000_010a, 32'h0000_010a}};
    tsdc_peer peer (.i_clk(clk), .i_rst_n(rst_n), .i_fire(fire), .o_iti(iti));
    tsdc_timer dut (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wr_data(wdata),
        .i_wr_en(wr), .i_rd_en(rd), .o_rd_data(rdata), .i_internal_trigger_in(iti),
        .i_channel0_input(ch0), .i_debug_halted(halt), .o_trigger_out(trg),
        .o_dma_req(dreq));
    always #5 clk = ~clk;
    task automatic give_verdict();
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        // gap cycle so the strobe is never assigned twice in one step
        @(posedge clk);
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata === e, "read data");
        @(posedge clk);
    endtask
    // bounded wait; checked off the edge so the request has settled
    task automatic wait_req();
        for (int k = 0; k < 50 && dreq !== 1'b1; k++) @(negedge clk);
        chk(dreq === 1'b1, "dma request");
        @(posedge clk);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            give_verdict();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd_reg(8'h00, 32'h0000_0000);
        rd_reg(8'h2c, 32'h0000_ffff);
        foreach (rows[i]) begin
            wr_reg(rows[i].a, rows[i].w);
            rd_reg(rows[i].a, rows[i].e);
        end
        wr_reg(8'h04, 32'h0000_0001);
        wr_reg(8'h08, 32'h0000_0026);
        fire <= 1'b1;
        repeat (10) @(posedge clk);
        fire <= 1'b0;
        rd_reg(8'h00, 32'h0000_0001);
        @(negedge clk) chk(trg === 1'b1, "enable out");
        @(posedge clk);
        wr_reg(8'h08, 32'h0000_0000);
        wr_reg(8'h0c, 32'h0000_0001);
        wait_req();
        // stop counting so no fresh update restarts the burst early
        wr_reg(8'h00, 32'h0000_0000);
        wr_reg(8'h4c, 32'h0000_0003);
        wait_req();
        wr_reg(8'h4c, 32'h0000_0005);
        repeat (2) @(posedge clk);
        chk(dreq === 1'b0, "burst length");
        rd_reg(8'h28, 32'h0000_0003);
        rd_reg(8'h2c, 32'h0000_0005);
        wr_reg(8'h14, 32'h0000_0001);
        wait_req();
        wr_reg(8'h4c, 32'h0000_0009);
        rd_reg(8'h28, 32'h0000_0009);
        wr_reg(8'h50, 32'h0000_0001);
        wr_reg(8'h00, 32'h0000_0001);
        halt <= 1'b1;
        wr_reg(8'h24, 32'h0000_0002);
        // long enough for a prescaled step if the hold were broken
        repeat (20) @(posedge clk);
        rd_reg(8'h24, 32'h0000_0002);
        halt <= 1'b0;
        // channel 0 edge in event mode, own response held back by sync
        wr_reg(8'h00, 32'h0000_0000);
        wr_reg(8'h24, 32'h0000_0000);
        wr_reg(8'h10, 32'h0000_0007);
        wr_reg(8'h08, 32'h0000_00c6);
        ch0 <= 1'b1;
        repeat (6) @(posedge clk);
        rd_reg(8'h00, 32'h0000_0000);
        rd_reg(8'h10, 32'h0000_0004);
        rd_reg(8'h00, 32'h0000_0001);
        // peer pulses as external clock, own update on trigger output
        wr_reg(8'h08, 32'h0000_0027);
        wr_reg(8'h28, 32'h0000_0000);
        wr_reg(8'h24, 32'h0000_0000);
        wr_reg(8'h04, 32'h0000_0002);
        wr_reg(8'h00, 32'h0000_0001);
        repeat (5) begin
            fire <= 1'b1;
            repeat (4) @(posedge clk);
            fire <= 1'b0;
            repeat (4) @(posedge clk);
        end
        rd_reg(8'h24, 32'h0000_0005);
        fire <= 1'b1;
        for (int k = 0; k < 8 && trg !== 1'b1; k++) @(negedge clk);
        chk(trg === 1'b1, "update out");
        give_verdict();
    end
endmodule
`default_nettype wire
